// >>> design/insn_decode.sv
// decoder and executor for bit invert, two branches and the two-word long call
// assumes data memory answers a read combinationally in the same cycle
`timescale 1ns/100ps
`include "insn_defs.svh"
module insn_decode
	import insn_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [3:0]  adr_i,
	input  wire logic [31:0] dat_i,
	input  wire logic        we_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic [7:0]  w_i,
	input  wire logic [7:0]  bank_select_register_i,
	input  wire logic [7:0]  fsr_base_i,
	input  wire logic [7:0]  dmem_rdata_i,
	output dmem_req_s        dmem_o,
	output logic      [20:0] pc_o,
	output logic      [20:0] push_data_o,
	output logic             push_o,
	output logic      [7:0]  working_shadow_o,
	output logic      [7:0]  status_shadow_o,
	output logic      [7:0]  bank_select_shadow_o,
	output logic             busy_o
);
// ==========================================
// decode helpers
// the first call word is looked for both in the issued slot and in the
// held slot; one function keeps the two compares from drifting apart
function automatic logic is_call_word1(input logic [15:0] word);
	return word[15:9] == `OP_CALL_HI;
endfunction
// both conditional branches share the opcode byte plus offset byte layout
function automatic logic is_branch_word(input logic [15:0] word, input logic [7:0] op);
	return word[15:8] == op;
endfunction
// ==========================================
// state
logic [15:0] insn_r;
logic [15:0] first_r;
logic        ext_en_r;
logic [7:0]  status_r;
logic [20:0] pc_r;
logic        ack_r;
logic        go_r;
seq_e        seq_r;
seq_e        seq_nxt;
// ==========================================
// bus slave: writing the instruction register issues it
// a request is answered one cycle later; the write lands on the edge at
// which the master samples ack high, never on the request edge
wire         req       = cyc_i & stb_i & ~ack_r;
wire         ack_edge  = cyc_i & stb_i & ack_r;
wire         wr_en     = ack_edge & we_i & sel_i[0];
wire         wr_insn   = wr_en & (adr_i == `REG_INSN);
wire         wr_ctrl   = wr_en & (adr_i == `REG_CTRL);
wire         wr_stat   = wr_en & (adr_i == `REG_STATUS);
wire [15:0]  wdata     = {sel_i[1] ? dat_i[15:8] : insn_r[15:8], dat_i[7:0]};
// ==========================================
// decode
wire         is_btg    = insn_r[15:12] == `OP_BIT_INVERT;
wire         is_bov    = is_branch_word(insn_r, `OP_BRANCH_OV);
wire         is_bz     = is_branch_word(insn_r, `OP_BRANCH_ZERO);
wire         is_call1  = is_call_word1(insn_r);
wire         is_call2  = insn_r[15:12] == `OP_CALL_SECOND;
// any word but a call word ends the wait and runs normally; a first call word starts a new wait
wire         call_wait = is_call_word1(first_r);
wire         exec      = go_r && seq_r == ST_EXEC;
wire         call_done = exec & call_wait & is_call2;
wire         take      = (is_bov & status_r[`ST_OV]) | (is_bz & status_r[`ST_ZERO]);
wire         to_nop    = exec & (is_call1 | take | call_done);
// ==========================================
// file register addressing
wire [2:0]   bitno     = insn_r[11:9];
wire         acc_a     = insn_r[8];
wire [7:0]   faddr     = insn_r[7:0];
wire         indexed   = ~acc_a & ext_en_r & (faddr <= `INDEXED_LIMIT);
// access bank low half maps to bank 0, upper half to bank 15
wire [11:0]  acc_addr  = faddr[7] ? {4'hF, faddr} : {4'h0, faddr};
wire [11:0]  bank_addr = {bank_select_register_i[3:0], faddr};
// summed at full address width so a large base does not wrap in page 0
wire [11:0]  idx_addr  = {4'h0, fsr_base_i} + {4'h0, faddr};
wire [11:0]  eff_addr  = indexed ? idx_addr : (acc_a ? bank_addr : acc_addr);
// ==========================================
// bit invert: one xor per data bit, only the selected one is live
wire [7:0]   flipped;
genvar g;
generate
	for (g = 0; g < 8; g = g + 1)
	begin : g_flip
		assign flipped[g] = dmem_rdata_i[g] ^ (bitno == 3'(g));
	end
endgenerate
// ==========================================
// program counter arithmetic
wire [20:0]  offs2     = {{12{insn_r[7]}}, insn_r[7:0], 1'b0};
wire [20:0]  pc_inc    = pc_r + `PC_STEP;
wire [20:0]  br_tgt    = pc_inc + offs2;
wire [19:0]  call_k    = {insn_r[11:0], first_r[7:0]};
wire [20:0]  call_tgt  = {call_k, 1'b0};
wire [20:0]  ret_addr  = pc_r + `CALL_RET_STEP;
wire         shadow_en = call_done & first_r[8];
// ==========================================
// register bus read mux
always_comb
begin
	case (adr_i)
		`REG_INSN:   dat_o = {16'h0000, insn_r};
		`REG_CTRL:   dat_o = {31'h00000000, ext_en_r};
		`REG_STATUS: dat_o = {24'h000000, status_r};
		`REG_PC:     dat_o = {11'h000, pc_r};
		default:     dat_o = 32'h00000000;
	endcase
end
// ==========================================
// outputs
assign ack_o  = ack_r;
assign pc_o   = pc_r;
assign busy_o = go_r | (seq_r == ST_NOP);
always_comb
begin
	dmem_o.addr    = eff_addr;
	dmem_o.indexed = indexed;
	dmem_o.data    = flipped;
	dmem_o.wr      = exec & is_btg;
end
// ==========================================
// sequencer: a taken branch or either call word is followed by a no-op
// cycle; after the first call word it waits there for the next issued word
always_comb
begin
	seq_nxt = seq_r;
	case (seq_r)
		ST_EXEC:
			if (to_nop)
				seq_nxt = ST_NOP;
		ST_NOP:
			if (!call_wait || go_r)
				seq_nxt = ST_EXEC;
		default:
			seq_nxt = ST_EXEC;
	endcase
end
always_ff @(posedge clk_i)
begin
	if (rst_i)
		seq_r <= ST_EXEC;
	else
		seq_r <= seq_nxt;
end
// ==========================================
// bus registers
always_ff @(posedge clk_i)
begin
	if (rst_i)
	begin
		ack_r    <= 1'b0;
		ext_en_r <= 1'b0;
		status_r <= 8'h00;
	end
	else
	begin
		ack_r <= req;
		if (wr_ctrl)
			ext_en_r <= dat_i[`CTRL_EXT_EN];
		// status only changes by software; none of these ops touch it
		if (wr_stat)
			status_r <= dat_i[7:0];
	end
end
// ==========================================
// issue: go_r keeps the written word pending until its execute cycle
always_ff @(posedge clk_i)
begin
	if (rst_i)
	begin
		insn_r <= 16'h0000;
		go_r   <= 1'b0;
	end
	else if (wr_insn)
	begin
		insn_r <= wdata;
		go_r   <= 1'b1;
	end
	else if (exec)
		go_r <= 1'b0;
end
// ==========================================
// held first call word, cleared by the next executed word unless that is itself a first call word
always_ff @(posedge clk_i)
begin
	if (rst_i)
		first_r <= 16'h0000;
	else if (exec)
		first_r <= is_call1 ? insn_r : 16'h0000;
end
// ==========================================
// program counter; the first call word leaves it where it is
always_ff @(posedge clk_i)
begin
	if (rst_i)
		pc_r <= 21'h000000;
	else if (call_done)
		pc_r <= call_tgt;
	else if (exec && take)
		pc_r <= br_tgt;
	else if (exec && !is_call1)
		pc_r <= pc_inc;
end
// ==========================================
// return stack push and shadow copies
always_ff @(posedge clk_i)
begin
	if (rst_i)
	begin
		push_o               <= 1'b0;
		push_data_o          <= 21'h000000;
		working_shadow_o     <= 8'h00;
		status_shadow_o      <= 8'h00;
		bank_select_shadow_o <= 8'h00;
	end
	else
	begin
		push_o <= call_done;
		if (call_done)
			push_data_o <= ret_addr;
		if (shadow_en)
		begin
			working_shadow_o     <= w_i;
			status_shadow_o      <= status_r;
			bank_select_shadow_o <= bank_select_register_i;
		end
	end
end
endmodule

// >>> inc/insn_defs.svh
// constants for the bit-invert, branch and long-call decoder
// assumes a 16-bit instruction word and a 21-bit byte program counter
`ifndef INSN_DEFS_SVH
`define INSN_DEFS_SVH
// ==========================================
// opcode patterns
`define OP_BIT_INVERT     4'h7
`define OP_BRANCH_OV      8'hE4
`define OP_BRANCH_ZERO    8'hE0
`define OP_CALL_HI        7'h76
`define OP_CALL_SECOND    4'hF
`define INDEXED_LIMIT     8'h5F
// ==========================================
// register offsets on the bus (byte addresses)
`define REG_INSN          4'h0
`define REG_CTRL          4'h4
`define REG_STATUS        4'h8
`define REG_PC            4'hC
// ==========================================
// control and status bit positions, program counter steps
`define CTRL_EXT_EN       0
`define ST_ZERO           2
`define ST_OV             3
`define PC_STEP           21'h000002
`define CALL_RET_STEP     21'h000004
`endif

// >>> inc/insn_pkg.sv
// types shared by the decoder
// assumes nothing beyond the defs header
package insn_pkg;
	typedef enum logic [1:0] {
		ST_EXEC = 2'b01,
		ST_NOP  = 2'b10
	} seq_e;
	typedef struct packed {
		logic        wr;
		logic [11:0] addr;
		logic [7:0]  data;
		logic        indexed;
	} dmem_req_s;
endpackage

// >>> verification/insn_monitor.sv
// checker on the decoder ports
// assumes a bind onto the decoder
`timescale 1ns/100ps
module insn_monitor
	import insn_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        ack_o,
	input wire dmem_req_s   dmem_o,
	input wire logic [7:0]  dmem_rdata_i,
	input wire logic [20:0] pc_o,
	input wire logic [20:0] push_data_o,
	input wire logic        push_o,
	input wire logic [7:0]  working_shadow_o,
	input wire logic        busy_o
);
	// ====
	// rules
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	bus_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o) else $error("ack");
	wr_pulse_a: assert property (dmem_o.wr |=> !dmem_o.wr) else $error("wr");
	one_bit_a: assert property (dmem_o.wr |-> $onehot(dmem_o.data ^ dmem_rdata_i)) else $error("bit");
	invert_step_a: assert property (dmem_o.wr |=> pc_o == $past(pc_o) + 21'h2) else $error("step");
	ret_addr_a: assert property (push_o |-> push_data_o == $past(pc_o) + 21'h4) else $error("ret");
	push_pulse_a: assert property (push_o |=> !push_o) else $error("push");
	pc_even_a: assert property (pc_o[0] == 1'h0) else $error("odd");
	shadow_hold_a: assert property (!push_o |-> $stable(working_shadow_o)) else $error("shadow");
	call_nop_a: assert property (push_o |-> busy_o) else $error("call nop");
	cover property (dmem_o.wr);
	cover property (push_o);
	cover property (push_o && working_shadow_o != $past(working_shadow_o));
endmodule
bind insn_decode insn_monitor insn_monitor_inst (.*);

// >>> verification/dmem_model.sv
// data memory partner, 4096 bytes
// assumes reads answer in the same cycle
`timescale 1ns/100ps
module dmem_model
	import insn_pkg::*;
(
	input wire logic      clk_i,
	input wire dmem_req_s req_i,
	output logic [7:0]    rdata_o
);
	// ====
	// store
	logic [7:0] mem [4096];
	initial
		foreach (mem[j])
			mem[j] = j[7:0];
	assign rdata_o = mem[req_i.addr];
	always @(posedge clk_i)
		if (req_i.wr)
			mem[req_i.addr] <= req_i.data;
endmodule

// >>> verification/tb.sv
// bench: wishbone driver, memory image and pc model
// assumes the memory partner and the bound checker
`timescale 1ns/100ps
`include "insn_defs.svh"
module tb;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, push_o, busy_o;
	logic [3:0] adr_i;
	logic [31:0] dat_i, dat_o, rd;
	logic [7:0] w_i, bank_i, base_i, rdata, sh_w, sh_s, sh_b, st, ew, es, eb;
	logic [20:0] pc_o, push_data_o, pc;
	logic [11:0] ad;
	logic [7:0] img [4096];
	insn_pkg::dmem_req_s dmem;
	int n_mismatch, checks, i, k, nb;
	insn_decode insn_decode_inst (.*, .sel_i(4'hF), .bank_select_register_i(bank_i), .fsr_base_i(base_i),
		.dmem_rdata_i(rdata), .dmem_o(dmem), .working_shadow_o(sh_w), .status_shadow_o(sh_s),
		.bank_select_shadow_o(sh_b));
	dmem_model dmem_model_inst (.clk_i(clk_i), .req_i(dmem), .rdata_o(rdata));
	initial
	begin
		clk_i = 1'h0;
		forever #4 clk_i = ~clk_i;
	end
	task automatic chk(string nm, logic [31:0] seen, exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict;
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// no fixed latency assumed: wait for ack under a bound
	task automatic wb(logic [3:0] a, logic [31:0] d, logic w);
		int j;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, d};
		for (j = 0; j < 9 && ack_o !== 1'h1; j++)
			@(posedge clk_i);
		rd = dat_o;
		{cyc_i, stb_i} <= 2'h0;
		if (j == 9)
		begin
			n_mismatch++;
			print_verdict();
		end
	endtask
	task automatic idle;
		@(posedge clk_i);
		for (nb = 0; nb < 9 && busy_o !== 1'h0; nb++)
			@(posedge clk_i);
		if (nb == 9)
		begin
			n_mismatch++;
			print_verdict();
		end
	endtask
	initial
	begin
		{cyc_i, stb_i, we_i, adr_i, dat_i, w_i, bank_i, base_i, pc, ew, es, eb} = '0;
		rst_i = 1'h1;
		foreach (img[j])
			img[j] = j[7:0];
		void'($urandom(32'h422cbeb2));
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		for (i = 0; i < 12; i++)
		begin
			k = $urandom;
			{bank_i, base_i} <= k[23:8];
			wb(`REG_CTRL, k[24], 1'h1);
			ad = (k[24] && !k[28] && k[7:0] <= `INDEXED_LIMIT) ? 12'(k[15:8]) + k[7:0] :
				{k[28] ? k[19:16] : {4{k[7]}}, k[7:0]};
			wb(`REG_INSN, {`OP_BIT_INVERT, k[27:25], k[28], k[7:0]}, 1'h1);
			idle();
			img[ad][k[27:25]] = ~img[ad][k[27:25]];
			pc += `PC_STEP;
			chk("mem", dmem_model_inst.mem[ad], img[ad]);
			chk("cycles", nb, 1);
			wb(`REG_PC, 0, 1'h0);
			chk("pc", rd, pc);
		end
		for (i = 0; i < 8; i++)
		begin
			k = $urandom;
			st = 8'h1 << ((i[1] == i[0]) ? `ST_OV : `ST_ZERO);
			wb(`REG_STATUS, st, 1'h1);
			wb(`REG_INSN, {i[1] ? `OP_BRANCH_OV : `OP_BRANCH_ZERO, k[7:0]}, 1'h1);
			idle();
			pc += `PC_STEP + (i[0] ? {{12{k[7]}}, k[7:0], 1'h0} : 21'h0);
			wb(`REG_PC, 0, 1'h0);
			chk("pc", rd, pc);
			chk("cycles", nb, i[0] ? 2 : 1);
		end
		for (i = 0; i < 2; i++)
		begin
			k = $urandom;
			w_i <= k[27:20];
			wb(`REG_INSN, {`OP_CALL_HI, i[0], k[7:0]}, 1'h1);
			wb(`REG_INSN, {`OP_CALL_SECOND, k[19:8]}, 1'h1);
			idle();
			chk("ret", push_data_o, 21'(pc + `CALL_RET_STEP));
			pc = {k[19:0], 1'h0};
			wb(`REG_PC, 0, 1'h0);
			chk("pc", rd, pc);
			if (i)
				{ew, es, eb} = {w_i, st, bank_i};
			chk("shadow", {sh_w, sh_s, sh_b}, {ew, es, eb});
		end
		print_verdict();
	end
endmodule
